/* src/dpt_pkg.sv */
// constants for the ddr2 precharge-timing command controller
package dpt_pkg;
    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int SYS_NS   = 10;            // sys_clk period, ns
    localparam int CK_DIV   = 2;             // sys_clk cycles per ck
    localparam int CK_NS    = SYS_NS * CK_DIV; // ddr ck period, ns
    // ------------------------------------------------------------
    // analog times, ns (plain defaults)
    // ------------------------------------------------------------
    localparam int T_RAS_NS = 45;            // activate to precharge
    localparam int T_RP_NS  = 15;            // precharge period
    localparam int T_RC_NS  = 60;            // activate to activate
    localparam int T_RTP_NS = 8;             // read to precharge
    localparam int T_WR_NS  = 15;            // write recovery
    // ------------------------------------------------------------
    // derived ck counts: least times round up
    // ------------------------------------------------------------
    localparam int RAS_CK   = (T_RAS_NS + CK_NS - 1) / CK_NS;
    localparam int RP_CK    = (T_RP_NS + CK_NS - 1) / CK_NS;
    localparam int RC_CK    = (T_RC_NS + CK_NS - 1) / CK_NS;
    localparam int RTP_CK   = (T_RTP_NS + CK_NS - 1) / CK_NS;
    localparam int WR_CK    = (T_WR_NS + CK_NS - 1) / CK_NS;
    localparam int RTPRP_CK = (T_RTP_NS + T_RP_NS + CK_NS - 1) / CK_NS;
    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int NBANK    = 8;             // banks
    localparam int BA_W     = 3;             // bank address width
    localparam int ADDR_W   = 14;            // address pins
    localparam int AP_BIT   = 10;            // auto-precharge / all bit
    localparam int TW       = 8;             // timer width
    // ------------------------------------------------------------
    // user request codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPT_ACT = 2'b00,
        DPT_RD  = 2'b01,
        DPT_WR  = 2'b10,
        DPT_PRE = 2'b11
    } dpt_cmd_t;
endpackage : dpt_pkg

/* src/dpt_ctrl.sv */
// ddr2 command controller keeping precharge and activate spacing
`timescale 1ns/100ps
module dpt_ctrl #(
    parameter int AL = 0,                    // additive latency
    parameter int CL = 3,                    // cas latency
    parameter int BL = 4                     // burst length, 4 or 8
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic [1:0]                    req_cmd,
    input  wire logic [dpt_pkg::BA_W-1:0]      req_bank,
    input  wire logic [dpt_pkg::ADDR_W-1:0]    req_addr,
    input  wire logic                          req_ap,
    output logic [dpt_pkg::NBANK-1:0]          bank_open,
    output logic                               ddr_ck,
    output logic                               ddr_ck_n,
    output logic                               ddr_cke,
    output logic                               ddr_cs_n,
    output logic                               ddr_ras_n,
    output logic                               ddr_cas_n,
    output logic                               ddr_we_n,
    output logic [dpt_pkg::BA_W-1:0]           ddr_ba,
    output logic [dpt_pkg::ADDR_W-1:0]         ddr_addr
);
    // ------------------------------------------------------------
    // derived spacings in ck cycles
    // ------------------------------------------------------------
    localparam int TW  = dpt_pkg::TW;
    localparam int NB  = dpt_pkg::NBANK;
    localparam int WL  = AL + CL - 1;
    localparam int PF  = (BL == 8) ? 2 : 0;  // last prefetch offset
    localparam int RTP2 = (dpt_pkg::RTP_CK > 2) ? dpt_pkg::RTP_CK : 2;
    // read to precharge spacing
    localparam int RD2PRE = AL + BL / 2 + RTP2 - 2;
    // write to precharge spacing, also after write ap
    localparam int WR2PRE = WL + BL / 2 + dpt_pkg::WR_CK;
    // read ap: nominal start plus trp
    localparam int RAP_NOM = AL + BL / 2 + dpt_pkg::RP_CK;
    // read ap: trtp pushout, trp joined without rounding
    localparam int RAP_RTP = AL + PF + dpt_pkg::RTPRP_CK;
    // write ap: burst end, write recovery, then trp
    localparam int WAP_ACT = WR2PRE + dpt_pkg::RP_CK;

    // refuse settings the timers cannot serve
    initial begin
        if (BL != 4 && BL != 8) begin
            $error("dpt_ctrl: burst length must be 4 or 8");
        end
        if (WAP_ACT + dpt_pkg::RAS_CK >= (1 << TW)) begin
            $error("dpt_ctrl: timer width too small");
        end
    end

    // ------------------------------------------------------------
    // ck divider: the controller makes the dram clock
    // ------------------------------------------------------------
    logic ck_r;                              // divided clock
    logic tick;                              // last sys_clk of a ck high

    // commands change as ck falls and are sampled as it rises
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ck_r <= 1'b0;
        end else begin
            ck_r <= ~ck_r;
        end
    end
    assign tick     = ck_r;
    assign ddr_ck   = ck_r;
    assign ddr_ck_n = ~ck_r;

    // ------------------------------------------------------------
    // per-bank state
    // ------------------------------------------------------------
    logic [TW-1:0] ras_r [NB];               // left of tras
    logic [TW-1:0] rc_r  [NB];               // left of trc
    logic [TW-1:0] pre_r [NB];               // until precharge allowed
    logic [TW-1:0] act_r [NB];               // until activate allowed
    logic [NB-1:0] open_r;                   // row open per bank
    logic          acc;                      // request taken
    logic          pre_all;                  // precharge names all banks
    logic          all_ok;                   // every bank may precharge
    logic [TW-1:0] ras_b;                    // addressed bank's tras

    assign pre_all = req_addr[dpt_pkg::AP_BIT];
    assign ras_b   = ras_r[req_bank];

    // larger of two timer values
    function automatic logic [TW-1:0] tmax(input logic [TW-1:0] a,
                                          input logic [TW-1:0] b);
        tmax = (a > b) ? a : b;
    endfunction : tmax

    // timer value after this ck's count-down, held at zero
    function automatic logic [TW-1:0] tdec(input logic [TW-1:0] a);
        tdec = (a != '0) ? a - 1'b1 : '0;
    endfunction : tdec

    // all-bank precharge needs tras and read/write spacing everywhere
    always_comb begin
        all_ok = 1'b1;
        for (int i = 0; i < NB; i++) begin
            if (ras_r[i] != '0 || pre_r[i] != '0) begin
                all_ok = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // request gating
    // ------------------------------------------------------------
    always_comb begin
        case (dpt_pkg::dpt_cmd_t'(req_cmd))
            // activate: closed bank, trp/ap done and trc met
            dpt_pkg::DPT_ACT: req_ready = tick && !open_r[req_bank]
                && act_r[req_bank] == '0
                && rc_r[req_bank] == '0;
            // column commands need an open row
            dpt_pkg::DPT_RD:  req_ready = tick && open_r[req_bank];
            dpt_pkg::DPT_WR:  req_ready = tick && open_r[req_bank];
            // precharge: tras and read/write spacing met
            dpt_pkg::DPT_PRE: req_ready = tick && (pre_all ? all_ok
                : (ras_b == '0 && pre_r[req_bank] == '0));
            default:          req_ready = 1'b0;
        endcase
    end
    assign acc = req_valid && req_ready;

    // ------------------------------------------------------------
    // timers: loaded on a command, counted down once per ck
    // ------------------------------------------------------------
    // a load of n lets the gated command through n+1 ck later, so every
    // spacing except precharge-all (loaded as RP_CK) is loaded minus one; merges use the counted-down value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NB; i++) begin
                ras_r[i] <= '0;
                rc_r[i]  <= '0;
                pre_r[i] <= '0;
                act_r[i] <= '0;
            end
            open_r <= '0;
        end else if (tick) begin
            for (int i = 0; i < NB; i++) begin
                // plain count-down; a load below overrides it
                ras_r[i] <= (ras_r[i] != '0) ? ras_r[i] - 1'b1 : '0;
                rc_r[i]  <= (rc_r[i]  != '0) ? rc_r[i]  - 1'b1 : '0;
                pre_r[i] <= (pre_r[i] != '0) ? pre_r[i] - 1'b1 : '0;
                act_r[i] <= (act_r[i] != '0) ? act_r[i] - 1'b1 : '0;
                if (acc) begin
                    case (dpt_pkg::dpt_cmd_t'(req_cmd))
                        dpt_pkg::DPT_ACT: begin
                            if (req_bank == i[2:0]) begin
                                ras_r[i]  <= TW'(dpt_pkg::RAS_CK - 1);
                                rc_r[i]   <= TW'(dpt_pkg::RC_CK - 1);
                                open_r[i] <= 1'b1;
                            end
                        end
                        dpt_pkg::DPT_RD: begin
                            if (req_bank == i[2:0]) begin
                                pre_r[i] <= tmax(tdec(pre_r[i]),
                                    TW'(RD2PRE - 1));
                                if (req_ap) begin
                                    // later of nominal, tras, trtp
                                    act_r[i] <= tmax(tmax(TW'(RAP_NOM - 1),
                                        TW'(RAP_RTP - 1)),
                                        ras_r[i] + TW'(dpt_pkg::RP_CK - 1));
                                    open_r[i] <= 1'b0;
                                end
                            end
                        end
                        dpt_pkg::DPT_WR: begin
                            if (req_bank == i[2:0]) begin
                                pre_r[i] <= tmax(tdec(pre_r[i]),
                                    TW'(WR2PRE - 1));
                                if (req_ap) begin
                                    // burst, recovery, then trp
                                    act_r[i] <= tmax(TW'(WAP_ACT - 1),
                                        ras_r[i] + TW'(dpt_pkg::RP_CK - 1));
                                    open_r[i] <= 1'b0;
                                end
                            end
                        end
                        dpt_pkg::DPT_PRE: begin
                            if (pre_all) begin
                                act_r[i] <= tmax(tdec(act_r[i]),
                                    TW'(dpt_pkg::RP_CK));
                                open_r[i] <= 1'b0;
                            end else if (req_bank == i[2:0]) begin
                                act_r[i] <= tmax(tdec(act_r[i]),
                                    TW'(dpt_pkg::RP_CK - 1));
                                open_r[i] <= 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end
    assign bank_open = open_r;

    // ------------------------------------------------------------
    // command pins: one command per ck, nop otherwise
    // ------------------------------------------------------------
    // precharges may follow on successive ck cycles, which is the
    // least spacing the one-command-per-ck pins can produce
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ddr_cke   <= 1'b0;
            ddr_cs_n  <= 1'b1;
            ddr_ras_n <= 1'b1;
            ddr_cas_n <= 1'b1;
            ddr_we_n  <= 1'b1;
            ddr_ba    <= '0;
            ddr_addr  <= '0;
        end else if (tick) begin
            ddr_cke <= 1'b1;
            if (acc) begin
                ddr_cs_n <= 1'b0;
                ddr_ba   <= req_bank;
                ddr_addr <= req_addr;
                case (dpt_pkg::dpt_cmd_t'(req_cmd))
                    dpt_pkg::DPT_ACT: begin
                        ddr_ras_n <= 1'b0;
                        ddr_cas_n <= 1'b1;
                        ddr_we_n  <= 1'b1;
                    end
                    dpt_pkg::DPT_RD: begin
                        ddr_ras_n <= 1'b1;
                        ddr_cas_n <= 1'b0;
                        ddr_we_n  <= 1'b1;
                        ddr_addr[dpt_pkg::AP_BIT] <= req_ap;
                    end
                    dpt_pkg::DPT_WR: begin
                        ddr_ras_n <= 1'b1;
                        ddr_cas_n <= 1'b0;
                        ddr_we_n  <= 1'b0;
                        ddr_addr[dpt_pkg::AP_BIT] <= req_ap;
                    end
                    default: begin
                        // precharge: a10 picks one bank or all
                        ddr_ras_n <= 1'b0;
                        ddr_cas_n <= 1'b1;
                        ddr_we_n  <= 1'b0;
                    end
                endcase
            end else begin
                ddr_cs_n  <= 1'b1;
                ddr_ras_n <= 1'b1;
                ddr_cas_n <= 1'b1;
                ddr_we_n  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_cmd_held;
        !ddr_cs_n [*2];
    endsequence
    // pins go back to nop unless the next ck took a command
    sequence s_nop_next;
        ddr_cs_n || $past(acc);
    endsequence

    property p_pre_bank;
        @(posedge sys_clk) disable iff (rst)
        acc && req_cmd == 2'b11 && !pre_all |=> !ddr_ras_n && !ddr_we_n
            && ddr_ba == $past(req_bank) && !ddr_addr[dpt_pkg::AP_BIT];
    endproperty
    chk_pre_bank_decode: assert property (p_pre_bank)
        else $error("single precharge pins wrong");

    chk_pre_tras_met: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd == 2'b11 && !pre_all |-> ras_b == '0)
        else $error("precharge before tras");

    chk_act_trp_trc: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd == 2'b00 |->
            act_r[req_bank] == '0 && rc_r[req_bank] == '0)
        else $error("activate before trp or trc");

    chk_rd_pre_load: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd == 2'b01 |=> pre_r[$past(req_bank)] >= RD2PRE - 1)
        else $error("read to precharge spacing not loaded");

    chk_wr_pre_load: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd == 2'b10 |=> pre_r[$past(req_bank)] >= WR2PRE - 1)
        else $error("write to precharge spacing not loaded");

    chk_ap_closes_bank: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd[1] != req_cmd[0] && req_ap
            |=> !open_r[$past(req_bank)] && ddr_addr[dpt_pkg::AP_BIT])
        else $error("auto-precharge did not close bank");

    chk_noap_keeps_open: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd[1] != req_cmd[0] && !req_ap
            |=> open_r[$past(req_bank)] && !ddr_addr[dpt_pkg::AP_BIT])
        else $error("plain read/write closed bank");

    chk_pre_all_period: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd == 2'b11 && pre_all |=> open_r == '0
            && act_r[0] >= TW'(dpt_pkg::RP_CK))
        else $error("precharge-all period wrong");

    chk_rap_late: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc && req_cmd == 2'b01 && req_ap |=>
            act_r[$past(req_bank)] >= $past(ras_b) + dpt_pkg::RP_CK - 1)
        else $error("read ap ignored tras");

    chk_cmd_one_ck: assert property (@(posedge sys_clk)
        disable iff (rst)
        acc |=> s_cmd_held ##1 s_nop_next)
        else $error("command not held one ck");
endmodule : dpt_ctrl

/* sim/dpt_dram_model.sv */
// behavioural ddr2 device: decodes commands, flags spacing violations
`timescale 1ns/100ps
module dpt_dram_model #(
    parameter int AL = 0,                      // additive latency
    parameter int CL = 3,                      // cas latency
    parameter int BL = 4                       // burst length, 4 or 8
) (
    input  wire logic                          ddr_ck,
    input  wire logic                          ddr_cke,
    input  wire logic                          ddr_cs_n,
    input  wire logic                          ddr_ras_n,
    input  wire logic                          ddr_cas_n,
    input  wire logic                          ddr_we_n,
    input  wire logic [dpt_pkg::BA_W-1:0]      ddr_ba,
    input  wire logic [dpt_pkg::ADDR_W-1:0]    ddr_addr,
    output logic [dpt_pkg::NBANK-1:0]          open_mask,
    output logic [15:0]                        viol_cnt
);
    // ------------------------------------------------------------
    // bookkeeping, every time in ck edges
    // ------------------------------------------------------------
    localparam int WL   = AL + CL - 1;         // write latency
    localparam int PF   = (BL == 8) ? 2 : 0;   // last prefetch offset
    localparam int RTP2 = (dpt_pkg::RTP_CK > 2) ? dpt_pkg::RTP_CK : 2;
    int cyc     = 0;                           // ck edge count
    int act_ok  [8];                           // earliest activate
    int pre_ok  [8];                           // earliest precharge
    int act_at  [8];                           // last activate edge
    int ap_go;                                 // ap start before rtp
    int b;                                     // addressed bank
    function automatic int mx(input int a, input int c);
        return (a > c) ? a : c;
    endfunction : mx
    initial begin
        open_mask = '0;
        viol_cnt  = '0;
        foreach (act_at[i]) begin
            act_at[i] = -1000;                 // long ago: no limit
            act_ok[i] = 0;
            pre_ok[i] = 0;
        end
    end
    // ------------------------------------------------------------
    // command decode on each rising ck edge
    // ------------------------------------------------------------
    // one command per edge, so precharges are at least one ck apart
    always @(posedge ddr_ck) begin
        cyc = cyc + 1;
        b   = int'(ddr_ba);
        if (ddr_cke === 1'b1 && ddr_cs_n === 1'b0) begin
            case ({ddr_ras_n, ddr_cas_n, ddr_we_n})
                3'b011: begin // activate
                    if (open_mask[b] || cyc < act_ok[b])
                        viol_cnt = viol_cnt + 1;
                    open_mask[b] = 1'b1;
                    act_at[b]    = cyc;
                    act_ok[b]    = cyc + dpt_pkg::RC_CK;
                    pre_ok[b]    = cyc + dpt_pkg::RAS_CK;
                end
                3'b010: begin // precharge, one bank or all
                    for (int i = 0; i < 8; i++) begin
                        if (ddr_addr[dpt_pkg::AP_BIT] || i == b) begin
                            if (cyc < pre_ok[i])
                                viol_cnt = viol_cnt + 1;
                            open_mask[i] = 1'b0;
                            act_ok[i] = mx(act_ok[i], cyc + dpt_pkg::RP_CK
                                + int'(ddr_addr[dpt_pkg::AP_BIT]));
                        end
                    end
                end
                3'b101, 3'b100: begin // read or write, a10 picks ap
                    if (!open_mask[b])
                        viol_cnt = viol_cnt + 1;
                    if (ddr_we_n) begin
                        pre_ok[b] = mx(pre_ok[b], cyc + AL + BL/2 + RTP2 - 2);
                        ap_go = mx(cyc + AL + BL/2,
                                   act_at[b] + dpt_pkg::RAS_CK);
                        // rtp push-out starts trp without edge rounding
                        ap_go = mx(ap_go + dpt_pkg::RP_CK,
                                   cyc + AL + PF + dpt_pkg::RTPRP_CK);
                    end else begin
                        pre_ok[b] = mx(pre_ok[b],
                                       cyc + WL + BL/2 + dpt_pkg::WR_CK);
                        ap_go = mx(cyc + WL + BL/2 + dpt_pkg::WR_CK,
                                   act_at[b] + dpt_pkg::RAS_CK)
                                + dpt_pkg::RP_CK;
                    end
                    if (ddr_addr[dpt_pkg::AP_BIT]) begin
                        open_mask[b] = 1'b0;
                        act_ok[b]    = mx(act_ok[b], ap_go);
                    end // a10 low leaves the row open
                end
                default: ;
            endcase
        end
    end
endmodule : dpt_dram_model

/* sim/dpt_ctrl_test.sv */
// self-checking bench for the ddr2 precharge-timing controller
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module dpt_ctrl_test;
    // ------------------------------------------------------------
    // settings and signals
    // ------------------------------------------------------------
    localparam int AL = 0, CL = 3, BL = 4;
    localparam int WL  = AL + CL - 1;          // write latency
    localparam int PF  = (BL == 8) ? 2 : 0;    // last prefetch offset
    localparam int R2P = AL + BL/2 - 2
        + ((dpt_pkg::RTP_CK > 2) ? dpt_pkg::RTP_CK : 2);
    localparam int W2P = WL + BL/2 + dpt_pkg::WR_CK;
    logic        sys_clk = 0, rst = 1, req_valid = 0, req_ready, req_ap = 0;
    logic [1:0]  req_cmd = '0;
    logic [2:0]  req_bank = '0, ddr_ba;
    logic [13:0] req_addr = '0, ddr_addr;
    logic [7:0]  bank_open, open_mask;
    logic [15:0] viol_cnt;
    logic        ddr_ck_n;
    logic        ddr_ck, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
    int          errors = 0, total_checks = 0, cyc = 0;
    int          ta, tb, tc, td;               // take edges, sys cycles
    dpt_ctrl #(.AL(AL), .CL(CL), .BL(BL)) i_dpt_ctrl (.sys_clk(sys_clk),
        .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
        .req_ap(req_ap), .bank_open(bank_open), .ddr_ck(ddr_ck),
        .ddr_ck_n(ddr_ck_n), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n),
        .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n),
        .ddr_ba(ddr_ba), .ddr_addr(ddr_addr));
    dpt_dram_model #(.AL(AL), .CL(CL), .BL(BL)) i_dpt_dram_model (
        .ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n),
        .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n),
        .ddr_ba(ddr_ba), .ddr_addr(ddr_addr), .open_mask(open_mask),
        .viol_cnt(viol_cnt));
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    function automatic int mx(input int a, input int c);
        return (a > c) ? a : c;
    endfunction : mx
    function automatic int ck(input int a, input int c);
        return (c - a) / 2;                     // sys cycles to ck
    endfunction : ck
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // valid stays up on return so back-to-back requests need no gap
    task automatic issue(input logic [1:0] cmd, input logic [2:0] bank,
                         input logic a10, input logic must, output int t);
        logic got;
        got       = 1'b0;
        req_valid = 1'b1;
        req_cmd   = cmd;
        req_bank  = bank;
        req_ap    = a10;
        req_addr  = {3'h0, a10, 10'h155};
        for (int n = 0; n < (must ? 200 : 12) && !got; n++) begin
            @(negedge sys_clk);
            if (req_ready === 1'b1) begin
                @(posedge sys_clk);
                t   = cyc;
                got = 1'b1;
            end
        end
        if (!got)
            @(posedge sys_clk);
        #1;
        `CHK(got, must)
        if (must && !got)
            close_out();
    endtask : issue
    task automatic idle(input int n);
        req_valid = 1'b0;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle
    task automatic settle(input string name);
        idle(40);
        `CHK(viol_cnt, 16'h0000)
        `CHK(open_mask, bank_open)
        `CHK(ddr_ck_n, ~ddr_ck)
        $display("test %s done", name);
    endtask : settle
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_read_pre;
        issue(dpt_pkg::DPT_RD, 3'h7, 1'b0, 1'b0, ta); // refused: closed
        issue(dpt_pkg::DPT_ACT, 3'h1, 1'b0, 1'b1, ta);
        issue(dpt_pkg::DPT_RD, 3'h1, 1'b0, 1'b1, tb);
        `CHK(ck(ta, tb), 1)
        `CHK(bank_open[1], 1'b1)
        issue(dpt_pkg::DPT_PRE, 3'h1, 1'b0, 1'b1, tc);
        `CHK(ck(ta, tc), mx(dpt_pkg::RAS_CK, 1 + R2P))
        issue(dpt_pkg::DPT_ACT, 3'h1, 1'b0, 1'b1, td);
        `CHK(ck(ta, td), mx(ck(ta, tc) + dpt_pkg::RP_CK, dpt_pkg::RC_CK))
        settle("read_pre");
    endtask : t_read_pre
    task automatic t_write_pre;
        issue(dpt_pkg::DPT_ACT, 3'h2, 1'b0, 1'b1, ta);
        issue(dpt_pkg::DPT_WR, 3'h2, 1'b0, 1'b1, tb);
        issue(dpt_pkg::DPT_PRE, 3'h2, 1'b0, 1'b1, tc);
        `CHK(ck(ta, tc), mx(dpt_pkg::RAS_CK, 1 + W2P))
        settle("write_pre");
    endtask : t_write_pre
    task automatic t_read_ap;
        issue(dpt_pkg::DPT_ACT, 3'h3, 1'b0, 1'b1, ta);
        issue(dpt_pkg::DPT_RD, 3'h3, 1'b1, 1'b1, tb);
        issue(dpt_pkg::DPT_ACT, 3'h3, 1'b0, 1'b1, tc);
        `CHK(ck(ta, tc), mx(mx(dpt_pkg::RC_CK, 1 + AL + PF + dpt_pkg::RTPRP_CK),
            mx(1 + AL + BL/2, dpt_pkg::RAS_CK) + dpt_pkg::RP_CK))
        settle("read_ap");
    endtask : t_read_ap
    task automatic t_write_ap;
        issue(dpt_pkg::DPT_ACT, 3'h4, 1'b0, 1'b1, ta);
        issue(dpt_pkg::DPT_WR, 3'h4, 1'b1, 1'b1, tb);
        issue(dpt_pkg::DPT_PRE, 3'h4, 1'b0, 1'b1, tc);
        `CHK(ck(tb, tc), W2P)
        issue(dpt_pkg::DPT_ACT, 3'h4, 1'b0, 1'b1, td);
        `CHK(ck(ta, td), mx(dpt_pkg::RC_CK, 1 + W2P + dpt_pkg::RP_CK))
        settle("write_ap");
    endtask : t_write_ap
    task automatic t_pre_select;
        issue(dpt_pkg::DPT_PRE, 3'h5, 1'b1, 1'b1, ta);
        idle(8);
        for (int i = 0; i < 8; i++)
            issue(dpt_pkg::DPT_ACT, 3'(i), 1'b0, 1'b1, ta);
        for (int i = 0; i < 8; i++) begin
            issue(dpt_pkg::DPT_PRE, 3'(i), 1'b0, 1'b1, tb);
            `CHK(bank_open, 8'hfe << i)
            if (i > 0)
                `CHK(ck(tc, tb), 1)
            tc = tb;
        end
        for (int i = 0; i < 8; i++)
            issue(dpt_pkg::DPT_ACT, 3'(i), 1'b0, 1'b1, ta);
        issue(dpt_pkg::DPT_PRE, 3'h5, 1'b1, 1'b1, tb);
        `CHK(bank_open, 8'h00)
        issue(dpt_pkg::DPT_ACT, 3'h6, 1'b0, 1'b1, tc);
        `CHK(ck(tb, tc), dpt_pkg::RP_CK + 1)
        settle("pre_select");
    endtask : t_pre_select
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        idle(2);
        t_read_pre();
        t_write_pre();
        t_read_ap();
        t_write_ap();
        t_pre_select();
        close_out();
    end
endmodule : dpt_ctrl_test
